// [mfc_bus_model.sv]
// behavioural bus controller answering hub operations
`timescale 1ns/1ns
`default_nettype none
module mfc_bus_model (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // answer latency chosen by the bench
   input wire logic [3:0] delay,
   // operation handshake
   input wire logic op_valid,
   output logic op_done
);
   logic [3:0] wait_q;
   // one done pulse per pending operation; the count restarts so chained reads wait again
   always_ff @(posedge core_clk) begin
      if (rst || !op_valid || op_done) begin
         wait_q <= 4'h0;
         op_done <= 1'b0;
      end else begin
         wait_q <= wait_q + 4'h1;
         op_done <= (wait_q == delay);
      end
   end
endmodule : mfc_bus_model
`default_nettype wire

// [mfc_chk.sv]
// assertion checker for the function configuration bank
`timescale 1ns/1ns
`default_nettype none
module mfc_chk (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // register port and levels
   input wire logic reg_wr,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic primary_bank_select,
   input wire logic accel_on,
   input wire logic hub_op_done,
   input wire logic hub_op_valid,
   // observed outputs
   input wire logic module_run,
   input wire logic tilt_run,
   input wire logic sign_motion_run,
   input wire logic step_count_run,
   input wire logic aux_pullup_on,
   input wire logic advanced_page,
   input wire logic hub_transfer_done
);
   default clocking @(posedge core_clk);
   endclocking
   default disable iff (rst);
   logic fwr;
   // function control is only reachable while the normal page is mapped
   assign fwr = reg_wr && reg_addr == mfc_pkg::ADDR_CONTROL && !advanced_page;
   AST_MODULE: assert property (fwr |=> module_run == $past(reg_wdata[5]))
      else $error("module enable mismatch");
   AST_TILT: assert property (fwr |=> tilt_run == $past(reg_wdata[4]))
      else $error("tilt enable mismatch");
   AST_PULLUP: assert property (fwr |=> aux_pullup_on == $past(reg_wdata[3]))
      else $error("pull-up enable mismatch");
   AST_SIGN: assert property (fwr |=> sign_motion_run == $past(reg_wdata[1]))
      else $error("motion enable mismatch");
   AST_STEP: assert property (fwr |=> step_count_run == $past(reg_wdata[0]))
      else $error("step enable mismatch");
   AST_ENTER: assert property (primary_bank_select && !advanced_page |=> advanced_page)
      else $error("page not entered");
   AST_STAY_OUT: assert property (!primary_bank_select && !advanced_page |=> !advanced_page)
      else $error("page entered without select");
   AST_LEAVE: assert property (advanced_page && reg_wr && reg_addr == 8'h3f
      && !reg_wdata[4] && !primary_bank_select |=> !advanced_page)
      else $error("page not left");
   AST_HUB_POWER: assert property (!accel_on |=> !hub_op_valid)
      else $error("hub runs while unpowered");
   AST_DONE_CAUSE: assert property ($rose(hub_transfer_done)
      |-> $past(hub_op_done) || $past(hub_op_done, 2))
      else $error("done without finished operation");
   AST_RESET: assert property ($fell(rst) |-> !(module_run || tilt_run
      || sign_motion_run || step_count_run || aux_pullup_on || hub_transfer_done))
      else $error("enable set after reset");
endmodule : mfc_chk
bind mfc_config_bank mfc_chk mfc_chk_i (.core_clk(core_clk), .rst(rst), .reg_wr(reg_wr),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .primary_bank_select(primary_bank_select),
   .accel_on(accel_on), .hub_op_done(hub_op_done), .hub_op_valid(hub_op_valid),
   .module_run(module_run), .tilt_run(tilt_run), .sign_motion_run(sign_motion_run),
   .step_count_run(step_count_run), .aux_pullup_on(aux_pullup_on),
   .advanced_page(advanced_page), .hub_transfer_done(hub_transfer_done));
`default_nettype wire

// [mfc_config_bank.sv]
// register bank for embedded motion functions and advanced page
`timescale 1ns/1ns
`default_nettype none
module mfc_config_bank #(
   parameter int DEB_UNIT_CYC = mfc_pkg::DEB_UNIT_CYC
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // register port from the serial interface
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   // primary page bank select from the primary control register
   input wire logic primary_bank_select,
   // accelerometer state and step events
   input wire logic accel_on,
   input wire logic step_event,
   // hub controller side
   input wire logic hub_start,
   input wire logic hub_op_done,
   output logic hub_op_valid,
   output logic hub_op_read,
   output logic [6:0] hub_op_target,
   output logic [7:0] hub_op_index,
   output logic [7:0] hub_op_wdata,
   // function enables and status
   output logic module_run,
   output logic tilt_run,
   output logic sign_motion_run,
   output logic step_count_run,
   output logic aux_pullup_on,
   output logic step_count_inc,
   output logic advanced_page,
   output logic hub_transfer_done
);
   logic [7:0] embedded_function_control_q;
   logic [7:0] adv_ctrl_q;
   logic [7:0] deb_q;
   logic [7:0] ext_addr_q;
   logic [7:0] ext_index_q;
   logic [7:0] hub_cfg_q;
   logic [7:0] wval_q;
   logic [7:0] ths_q;
   logic [7:0] window_q;
   logic adv_q;
   logic wr_adv;
   logic wr_norm;
   logic hub_done_pulse;
   logic hub_busy;
   mfc_pkg::mfc_hub_req_s hub_req;
   mfc_pkg::mfc_deb_cfg_s deb_cfg;

   assign wr_adv = reg_wr && adv_q;
   assign wr_norm = reg_wr && !adv_q;
   assign advanced_page = adv_q;

   // page select: mapping follows a one in the primary select bit
   always_ff @(posedge core_clk) begin
      if (rst) begin
         adv_q <= 1'b0;
      end else if (!adv_q && primary_bank_select) begin
         adv_q <= 1'b1;
      end else if (wr_adv && reg_addr == mfc_pkg::ADDR_CONTROL
                   && !reg_wdata[mfc_pkg::BIT_BANK_SEL]) begin
         adv_q <= 1'b0;
      end
   end

   // function control on the normal page; top bits kept as written
   always_ff @(posedge core_clk) begin
      if (rst) embedded_function_control_q <= mfc_pkg::RST_FUNC_CONTROL;
      else if (wr_norm && reg_addr == mfc_pkg::ADDR_CONTROL) embedded_function_control_q <= reg_wdata;
   end

   // advanced page storage; reserved offsets take no write at all
   always_ff @(posedge core_clk) begin
      if (rst) begin
         deb_q <= mfc_pkg::RST_STEP_DEBOUNCE;
         ext_addr_q <= mfc_pkg::RST_ZERO;
         ext_index_q <= mfc_pkg::RST_ZERO;
         hub_cfg_q <= mfc_pkg::RST_ZERO;
         wval_q <= mfc_pkg::RST_ZERO;
         ths_q <= mfc_pkg::RST_MOTION_THS;
         window_q <= mfc_pkg::RST_ZERO;
         adv_ctrl_q <= mfc_pkg::RST_ADV_CONTROL;
      end else if (!adv_q && primary_bank_select) begin
         // the select bit reads back as one while the page is mapped again
         adv_ctrl_q[mfc_pkg::BIT_BANK_SEL] <= 1'b1;
      end else if (wr_adv) begin
         case (reg_addr)
            mfc_pkg::ADDR_STEP_DEBOUNCE: deb_q <= reg_wdata;
            mfc_pkg::ADDR_EXT_ADDRESS: ext_addr_q <= reg_wdata;
            mfc_pkg::ADDR_EXT_INDEX: ext_index_q <= reg_wdata;
            mfc_pkg::ADDR_HUB_CONFIG: hub_cfg_q <= reg_wdata;
            mfc_pkg::ADDR_WRITE_VALUE: wval_q <= reg_wdata;
            mfc_pkg::ADDR_MOTION_THS: ths_q <= reg_wdata;
            mfc_pkg::ADDR_STEP_WINDOW: window_q <= reg_wdata;
            // only the select bit is writable, the rest mirrors read-only bits
            mfc_pkg::ADDR_CONTROL: adv_ctrl_q[mfc_pkg::BIT_BANK_SEL] <= reg_wdata[mfc_pkg::BIT_BANK_SEL];
            default: ;
         endcase
      end
   end

   // sticky transfer done flag; a new completion wins over the clear on a new start
   always_ff @(posedge core_clk) begin
      if (rst) hub_transfer_done <= 1'b0;
      else if (hub_done_pulse) hub_transfer_done <= 1'b1;
      else if (hub_start && !hub_busy) hub_transfer_done <= 1'b0;
   end

   // read data registered; unmapped offsets return zero
   always_ff @(posedge core_clk) begin
      if (rst) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         if (!adv_q) begin
            reg_rdata <= (reg_addr == mfc_pkg::ADDR_CONTROL) ? embedded_function_control_q : 8'h00;
         end else begin
            case (reg_addr)
               mfc_pkg::ADDR_STEP_DEBOUNCE: reg_rdata <= deb_q;
               mfc_pkg::ADDR_EXT_ADDRESS: reg_rdata <= ext_addr_q;
               mfc_pkg::ADDR_EXT_INDEX: reg_rdata <= ext_index_q;
               mfc_pkg::ADDR_HUB_CONFIG: reg_rdata <= hub_cfg_q;
               mfc_pkg::ADDR_WRITE_VALUE: reg_rdata <= wval_q;
               mfc_pkg::ADDR_MOTION_THS: reg_rdata <= ths_q;
               mfc_pkg::ADDR_STEP_WINDOW: reg_rdata <= window_q;
               mfc_pkg::ADDR_CONTROL: reg_rdata <= adv_ctrl_q;
               default: reg_rdata <= 8'h00;
            endcase
         end
      end
   end

   // enables drive the routines straight from the control register
   assign module_run = embedded_function_control_q[mfc_pkg::BIT_MODULE];
   assign tilt_run = embedded_function_control_q[mfc_pkg::BIT_TILT];
   assign aux_pullup_on = embedded_function_control_q[mfc_pkg::BIT_PULLUP];
   assign sign_motion_run = embedded_function_control_q[mfc_pkg::BIT_SIGN_MOT];
   assign step_count_run = embedded_function_control_q[mfc_pkg::BIT_STEP_CNT];

   // hub request built from the advanced page fields
   assign hub_req.target = ext_addr_q[7:1];
   assign hub_req.read = ext_addr_q[mfc_pkg::BIT_DIR];
   assign hub_req.index = ext_index_q;
   assign hub_req.wdata = wval_q;
   assign hub_req.read_count = hub_cfg_q[2:0];
   assign deb_cfg.time_units = deb_q[7:3];
   assign deb_cfg.min_steps = deb_q[2:0];

   // hub runs only with its enable and a powered accelerometer
   mfc_hub_sequencer u_hub (
      .core_clk(core_clk),
      .rst(rst),
      .enable(embedded_function_control_q[mfc_pkg::BIT_HUB_ON] && accel_on),
      .start(hub_start),
      .req(hub_req),
      .op_valid(hub_op_valid),
      .op_read(hub_op_read),
      .op_target(hub_op_target),
      .op_index(hub_op_index),
      .op_wdata(hub_op_wdata),
      .op_done(hub_op_done),
      .busy(hub_busy),
      .done_pulse(hub_done_pulse)
   );

   // step debouncer active only with the step counter routine
   mfc_step_debounce #(.UNIT_CYC(DEB_UNIT_CYC)) u_deb (
      .core_clk(core_clk),
      .rst(rst),
      .enable(step_count_run),
      .cfg(deb_cfg),
      .step_in(step_event),
      .count_inc(step_count_inc)
   );
endmodule : mfc_config_bank
`default_nettype wire

// [mfc_config_bank_tb.sv]
// self-checking testbench for the function configuration bank
`timescale 1ns/1ns
`default_nettype none
module mfc_config_bank_tb;
   logic core_clk, rst, reg_wr, reg_rd, primary_bank_select, accel_on, step_event, hub_start;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, hub_op_index, hub_op_wdata, v;
   logic [6:0] hub_op_target;
   logic [3:0] delay;
   logic [4:0] runs;
   logic hub_op_done, hub_op_valid, hub_op_read, module_run, tilt_run, sign_motion_run;
   logic step_count_run, aux_pullup_on, step_count_inc, advanced_page, hub_transfer_done;
   int mismatches, checks_done;
   logic [7:0] adv_addr [8] = '{8'h2b, 8'h30, 8'h31, 8'h32, 8'h33, 8'h34, 8'h3a, 8'h35};
   logic [7:0] adv_rst [8] = '{8'h6e, 8'h00, 8'h00, 8'h00, 8'h00, 8'h06, 8'h00, 8'h00};
   assign runs = {module_run, tilt_run, aux_pullup_on, sign_motion_run, step_count_run};
   // short debounce unit keeps the run brief
   mfc_config_bank #(.DEB_UNIT_CYC(10)) mfc_config_bank_i (.core_clk(core_clk), .rst(rst),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .primary_bank_select(primary_bank_select), .accel_on(accel_on),
      .step_event(step_event), .hub_start(hub_start), .hub_op_done(hub_op_done),
      .hub_op_valid(hub_op_valid), .hub_op_read(hub_op_read), .hub_op_target(hub_op_target),
      .hub_op_index(hub_op_index), .hub_op_wdata(hub_op_wdata), .module_run(module_run),
      .tilt_run(tilt_run), .sign_motion_run(sign_motion_run), .step_count_run(step_count_run),
      .aux_pullup_on(aux_pullup_on), .step_count_inc(step_count_inc),
      .advanced_page(advanced_page), .hub_transfer_done(hub_transfer_done));
   mfc_bus_model mfc_bus_model_i (.core_clk(core_clk), .rst(rst), .delay(delay),
      .op_valid(hub_op_valid), .op_done(hub_op_done));
   // free-running core clock
   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end
   task automatic give_verdict();
      if (mismatches == 0 && checks_done > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : give_verdict
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge core_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      @(negedge core_clk);
      check(reg_rdata, exp);
   endtask : rd
   // pulse the primary select so the advanced page maps in
   task automatic adv();
      @(posedge core_clk);
      primary_bank_select <= 1'b1;
      @(posedge core_clk);
      primary_bank_select <= 1'b0;
      @(negedge core_clk);
   endtask : adv
   task automatic hub(input int n, input logic r, input logic [7:0] wd);
      int ops;
      ops = 0;
      @(posedge core_clk);
      hub_start <= 1'b1;
      @(posedge core_clk);
      hub_start <= 1'b0;
      @(negedge core_clk);
      for (int i = 0; i < 60 && hub_transfer_done !== 1'b1; i++) begin
         @(negedge core_clk);
         if (hub_op_valid === 1'b1 && hub_op_done === 1'b1) begin
            check({hub_op_read, hub_op_target}, {r, 7'h2a});
            check(hub_op_index, 8'h10 + 8'(ops));
            if (!r) check(hub_op_wdata, wd);
            ops++;
         end
      end
      check(8'(ops), 8'(n));
      check({7'h0, hub_transfer_done}, {7'h0, n != 0});
      if (n != 0 && hub_transfer_done !== 1'b1) give_verdict();
   endtask : hub
   task automatic steps(input int n, input int gap, input logic [7:0] exp);
      int incs;
      incs = 0;
      for (int s = 0; s < n; s++) begin
         @(posedge core_clk);
         step_event <= 1'b1;
         @(posedge core_clk);
         step_event <= 1'b0;
         repeat (gap) begin
            @(negedge core_clk);
            if (step_count_inc === 1'b1) incs++;
         end
      end
      check(8'(incs), exp);
   endtask : steps
   // main sequence; top two function bits are always written zero
   initial begin
      {rst, reg_wr, reg_rd, primary_bank_select, accel_on, step_event, hub_start} = 7'h40;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      delay = 4'h2;
      repeat (10) @(posedge core_clk);
      rst <= 1'b0;
      rd(8'h3f, 8'h00);
      rd(8'h2b, 8'h00);
      for (int i = 0; i < 6; i++) begin
         v = 8'h01 << i;
         wr(8'h3f, v);
         @(negedge core_clk);
         check({3'h0, runs}, {3'h0, v[5], v[4], v[3], v[1], v[0]});
         rd(8'h3f, v);
      end
      wr(8'h3f, 8'h04);
      hub(0, 1'b0, 8'h00);
      wr(8'h3f, 8'h00);
      accel_on <= 1'b1;
      hub(0, 1'b0, 8'h00);
      adv();
      check({7'h0, advanced_page}, 8'h01);
      for (int i = 0; i < 8; i++) rd(adv_addr[i], adv_rst[i]);
      rd(8'h3f, 8'h14);
      // every writable advanced register except control is written and read back
      for (int i = 0; i < 7; i++) begin
         wr(adv_addr[i], 8'ha5 ^ 8'(i));
         rd(adv_addr[i], 8'ha5 ^ 8'(i));
      end
      wr(8'h30, 8'h54);
      wr(8'h31, 8'h10);
      wr(8'h32, 8'h03);
      wr(8'h33, 8'h5c);
      wr(8'h3f, 8'h00);
      rd(8'h3f, 8'h00);
      wr(8'h3f, 8'h04);
      delay <= 4'h6;
      hub(1, 1'b0, 8'h5c);
      adv();
      rd(8'h3f, 8'h14);
      wr(8'h30, 8'h55);
      wr(8'h3f, 8'h00);
      delay <= 4'h0;
      hub(3, 1'b1, 8'h00);
      wr(8'h3f, 8'h05);
      steps(8, 20, 8'h03);
      repeat (200) @(posedge core_clk);
      steps(5, 20, 8'h00);
      steps(1, 20, 8'h01);
      // second reset in mid-run must restore the function control and step debounce defaults
      @(posedge core_clk);
      rst <= 1'b1;
      repeat (10) @(posedge core_clk);
      rst <= 1'b0;
      rd(8'h3f, 8'h00);
      adv();
      rd(8'h2b, 8'h6e);
      give_verdict();
   end
endmodule : mfc_config_bank_tb
`default_nettype wire

// [mfc_hub_sequencer.sv]
// sensor hub transaction sequencer
`timescale 1ns/1ns
`default_nettype none
module mfc_hub_sequencer (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // control
   input wire logic enable,
   input wire logic start,
   input wire mfc_pkg::mfc_hub_req_s req,
   // bus controller side
   output logic op_valid,
   output logic op_read,
   output logic [6:0] op_target,
   output logic [7:0] op_index,
   output logic [7:0] op_wdata,
   input wire logic op_done,
   // status
   output logic busy,
   output logic done_pulse
);
   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_RUN = 2'b10
   } mfc_hub_state_e;
   mfc_hub_state_e state_q;
   logic [2:0] left_q;

   assign op_valid = (state_q == ST_RUN);
   assign busy = (state_q == ST_RUN);

   // transaction state; dropping the enable aborts at once
   always_ff @(posedge core_clk) begin
      done_pulse <= 1'b0;
      if (rst || !enable) begin
         state_q <= ST_IDLE;
         left_q <= 3'h0;
         op_read <= 1'b0;
         op_target <= 7'h0;
         op_index <= 8'h0;
         op_wdata <= 8'h0;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (start) begin
                  state_q <= ST_RUN;
                  op_target <= req.target;
                  op_read <= req.read;
                  op_index <= req.index;
                  op_wdata <= req.wdata;
                  left_q <= req.read ? req.read_count : 3'h0;
               end
            end
            ST_RUN: begin
               if (op_done) begin
                  if (op_read && left_q > 3'h1) begin
                     left_q <= left_q - 3'h1;
                     op_index <= op_index + 8'h1;
                  end else begin
                     state_q <= ST_IDLE;
                     done_pulse <= 1'b1;
                  end
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end
endmodule : mfc_hub_sequencer
`default_nettype wire

// [mfc_pkg.sv]
// package of constants and types for the motion function configuration bank
package mfc_pkg;
   // register offsets
   localparam logic [7:0] ADDR_STEP_DEBOUNCE = 8'h2b;
   localparam logic [7:0] ADDR_EXT_ADDRESS = 8'h30;
   localparam logic [7:0] ADDR_EXT_INDEX = 8'h31;
   localparam logic [7:0] ADDR_HUB_CONFIG = 8'h32;
   localparam logic [7:0] ADDR_WRITE_VALUE = 8'h33;
   localparam logic [7:0] ADDR_MOTION_THS = 8'h34;
   localparam logic [7:0] ADDR_STEP_WINDOW = 8'h3a;
   localparam logic [7:0] ADDR_CONTROL = 8'h3f;
   // reset values
   localparam logic [7:0] RST_STEP_DEBOUNCE = 8'h6e;
   localparam logic [7:0] RST_MOTION_THS = 8'h06;
   localparam logic [7:0] RST_ADV_CONTROL = 8'h14;
   localparam logic [7:0] RST_FUNC_CONTROL = 8'h00;
   localparam logic [7:0] RST_ZERO = 8'h00;
   // field positions
   localparam int BIT_STEP_CNT = 0;
   localparam int BIT_SIGN_MOT = 1;
   localparam int BIT_HUB_ON = 2;
   localparam int BIT_PULLUP = 3;
   localparam int BIT_TILT = 4;
   localparam int BIT_MODULE = 5;
   localparam int BIT_BANK_SEL = 4;
   localparam int BIT_DIR = 0;
   // timing: one debounce time unit
   localparam int DEB_UNIT_MS = 80;
   localparam int CLK_MHZ = 250;
   localparam int DEB_UNIT_CYC = DEB_UNIT_MS * 1000 * CLK_MHZ;
   // hub request to the bus controller
   typedef struct packed {
      logic [6:0] target;
      logic read;
      logic [7:0] index;
      logic [7:0] wdata;
      logic [2:0] read_count;
   } mfc_hub_req_s;
   // step debounce settings
   typedef struct packed {
      logic [4:0] time_units;
      logic [2:0] min_steps;
   } mfc_deb_cfg_s;
endpackage : mfc_pkg

// [mfc_step_debounce.sv]
// step debouncer gating step count increments
`timescale 1ns/1ns
`default_nettype none
module mfc_step_debounce #(
   parameter int UNIT_CYC = mfc_pkg::DEB_UNIT_CYC
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // control
   input wire logic enable,
   input wire mfc_pkg::mfc_deb_cfg_s cfg,
   input wire logic step_in,
   // result
   output logic count_inc
);
   logic [31:0] unit_q;
   logic [4:0] units_q;
   logic [2:0] seen_q;
   logic armed_q;
   logic gap_long;

   assign gap_long = (units_q > cfg.time_units);

   // interval timer in 80 ms units, restarted by each step
   always_ff @(posedge core_clk) begin
      if (rst || !enable || step_in) begin
         unit_q <= 32'h0;
         units_q <= 5'h0;
      end else if (unit_q == UNIT_CYC - 1) begin
         unit_q <= 32'h0;
         if (units_q != 5'h1f) units_q <= units_q + 5'h1; // saturate, never wrap
      end else begin
         unit_q <= unit_q + 32'h1;
      end
   end

   // debounce state: count steps until the minimum is reached
   always_ff @(posedge core_clk) begin
      if (rst || !enable) begin
         seen_q <= 3'h0;
         armed_q <= 1'b0;
      end else if (step_in) begin
         if (gap_long) begin
            seen_q <= 3'h1;
            armed_q <= (cfg.min_steps <= 3'h1);
         end else if (!armed_q) begin
            seen_q <= seen_q + 3'h1;
            armed_q <= (seen_q + 3'h1 >= cfg.min_steps);
         end
      end else if (gap_long) begin
         armed_q <= 1'b0;
         seen_q <= 3'h0;
      end
   end

   // pass a step only once debounced
   always_ff @(posedge core_clk) begin
      if (rst) count_inc <= 1'b0;
      else count_inc <= enable && step_in && armed_q && !gap_long;
   end
endmodule : mfc_step_debounce
`default_nettype wire
